// ==== adc_select_update_ctrl.sv ====
// Converter selection double buffering, start control and noise canceler.
// Assumes a single 25 MHz clock, synchronous CPU register port and
// synchronous trigger, sleep and comparator inputs.
//
// Behaviour
// R1: Temporary selection separate from effective selection
// R2: Copy while idle, freeze at start
// R3: Resume copying in final conversion cycle
// R4: Start on next converter clock edge
// R5: Software changes selection after one cycle
// R6: Software updates only in safe windows
// R7: Safe-window write affects next conversion
// R8: Free-running next conversion keeps old channel
// R9: Software avoids changes while free-running
// R10: Sleep entry starts conversion when halted
// R11: Completion raises request, wakes CPU
// R12: Other sleep modes leave converter enabled
// R13: Over-reference input gives full-scale code
// R14: Software discards first result after reference switch
// R15: Reference field decode
// R16: Channel field decode
// R17: Selection applied only while enabled
// R18: Start bit reads busy; zero write ignored
// R19: Lock identical for all start sources
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module adc_select_update_ctrl
	import adc_select_pkg::*;
#(
	parameter int presc_width = 7
) (
	input wire logic clk_sys_i, // System clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic [7:0] addr_i, // Register address
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [7:0] rdata_o, // Read data, cycle after strobe
	input wire logic trigger_i, // Selected auto-trigger source
	input wire logic free_run_i, // Trigger source is the done flag
	input wire logic cpu_halted_i, // CPU halted in sleep
	input wire logic [2:0] sleep_mode_i, // Sleep mode in use
	input wire logic over_ref_i, // Input exceeds reference
	input wire logic [9:0] sar_code_i, // Approximated code
	input wire logic irq_ack_i, // CPU takes completion vector
	output logic [1:0] ref_sel_o, // Effective reference
	output logic [3:0] chan_sel_o, // Effective channel
	output logic ref_pin_o, // Reference pin path
	output logic ref_supply_o, // Analog supply path
	output logic ref_internal_o, // Internal reference path
	output logic [7:0] input_onehot_o, // External input switches
	output logic temp_sel_o, // Temperature sensor path
	output logic bandgap_sel_o, // Bandgap path
	output logic ground_sel_o, // Ground path
	output logic sample_o, // Conversion running
	output logic [9:0] result_o, // Last result
	output logic done_irq_o, // Completion interrupt request
	output logic wake_o, // Wake request to sleep controller
	output logic irq_o // Status interrupt line
);

	state_type q; // Registered state
	state_type next_q; // Next state
	logic conv_tick; // Converter clock rising edge
	logic [6:0] presc_div; // Prescaler division
	logic sel_wr; // Selection register write
	logic ctl_wr; // Control register write
	logic start_req; // Any conversion start from idle
	logic trig_edge; // Rising trigger
	logic sleep_ok; // Noise canceler conditions
	logic conv_end; // Final converter cycle ends
	logic [1:0] irq_set; // Status events this cycle

	// Prescaler division from the select field
	always_comb begin
		case (q.presc_sel)
			3'h0, 3'h1: presc_div = 7'h01;
			3'h2: presc_div = 7'h03;
			3'h3: presc_div = 7'h07;
			3'h4: presc_div = 7'h0f;
			3'h5: presc_div = 7'h1f;
			3'h6: presc_div = 7'h3f;
			default: presc_div = 7'h7f;
		endcase
	end

	assign conv_tick = q.enable && (q.presc_cnt >= presc_div);
	assign sel_wr = wr_i && (addr_i == selection_register_offset);
	assign ctl_wr = wr_i && (addr_i == control_status_a_offset);
	// Edges while a conversion is running are ignored, prescaler included
	assign trig_edge = q.auto_trig && trigger_i && !q.trig_q
		&& q.state == st_idle_type && !q.start_busy;
	assign sleep_ok = q.enable && !q.start_busy && !q.auto_trig && q.done_ie;
	assign conv_end = conv_tick && (q.state == st_last_type);

	// Next-state logic for the whole block
	always_comb begin
		next_q = q;
		irq_set = 2'h0;
		next_q.trig_q = trigger_i;
		next_q.rdata = 8'h00;
		// Prescaler runs while enabled and restarts on trigger
		if (!q.enable || trig_edge || conv_tick) begin
			next_q.presc_cnt = 7'h00;
		end else begin
			next_q.presc_cnt = q.presc_cnt + 7'h01;
		end
		// Temporary selection is the CPU view
		if (sel_wr) begin
			next_q.selection_register = wdata_i; // R1
		end
		// Control writes
		if (ctl_wr) begin
			next_q.enable = wdata_i[enable_bit]; // R12
			next_q.auto_trig = wdata_i[auto_trig_bit];
			next_q.done_ie = wdata_i[done_ie_bit];
			next_q.presc_sel = wdata_i[presc_msb:0];
			if (wdata_i[start_bit] && wdata_i[enable_bit]) begin
				next_q.start_pending = 1'b1; // R4
				next_q.start_busy = 1'b1; // R18
			end
			if (wdata_i[enable_bit] && !q.enable) begin
				next_q.first_conv = 1'b1;
			end
		end
		// Noise canceler arms on a qualifying sleep entry
		if (cpu_halted_i && sleep_ok && !q.sleep_armed
			&& (sleep_mode_i == sleep_idle_code || sleep_mode_i == sleep_noise_code)) begin
			next_q.sleep_armed = 1'b1; // R10
			next_q.start_pending = 1'b1; // R10
			next_q.start_busy = 1'b1; // R10
		end
		if (!cpu_halted_i) begin
			next_q.sleep_armed = 1'b0;
		end
		// Auto-trigger edges start only when idle
		if (trig_edge && q.state == st_idle_type && !q.start_busy) begin
			next_q.start_pending = 1'b1; // R19
			next_q.start_busy = 1'b1; // R18
		end
		start_req = q.start_pending && conv_tick && q.state == st_idle_type;
		// Effective selection follows the temporary one while enabled, unless locked
		if (q.enable && (q.state == st_idle_type || q.state == st_last_type) && !start_req) begin
			next_q.eff.ref_sel = q.selection_register[ref_msb:ref_lsb]; // R2 R3 R17
			next_q.eff.chan_sel = q.selection_register[chan_msb:chan_lsb]; // R7
		end
		// Conversion sequencer on converter clock edges
		case (q.state)
			st_idle_type: begin
				if (start_req) begin
					next_q.state = st_convert_type; // R2 R19
					next_q.start_pending = 1'b0;
					next_q.cycle_cnt = q.first_conv ? first_conv_cycles - 5'h02
						: normal_conv_cycles - 5'h02;
					next_q.first_conv = 1'b0;
				end
			end
			st_convert_type: begin
				if (conv_tick) begin
					if (q.cycle_cnt == 5'h00) begin
						next_q.state = st_last_type; // R3
					end else begin
						next_q.cycle_cnt = q.cycle_cnt - 5'h01;
					end
				end
			end
			st_last_type: begin
				if (conv_tick) begin
					next_q.result = over_ref_i ? full_scale_code : sar_code_i; // R13
					next_q.done_flag = 1'b1;
					irq_set[irq_done_bit] = 1'b1;
					if (q.auto_trig && free_run_i) begin
						next_q.state = st_convert_type; // R8
						next_q.cycle_cnt = normal_conv_cycles - 5'h02;
					end else begin
						next_q.state = st_idle_type;
						// A start written on the completion edge keeps the bit set
						next_q.start_busy = next_q.start_pending; // R18
					end
					if (q.sleep_armed) begin
						irq_set[irq_wake_bit] = 1'b1; // R11
					end
				end
			end
			default: next_q.state = st_idle_type;
		endcase
		// Done flag clears by vector or one-write; completion wins
		if ((irq_ack_i || (ctl_wr && wdata_i[done_flag_bit])) && !conv_end) begin
			next_q.done_flag = 1'b0; // R11
		end
		// Disabling aborts any conversion
		if (ctl_wr && !wdata_i[enable_bit]) begin
			next_q.state = st_idle_type;
			next_q.start_pending = 1'b0;
			next_q.start_busy = 1'b0;
		end
		// Status register: write-one clear, set wins
		if (wr_i && addr_i == irq_clear_offset) begin
			next_q.irq_status = q.irq_status & ~wdata_i[1:0];
		end
		next_q.irq_status = next_q.irq_status | irq_set;
		if (wr_i && addr_i == irq_enable_offset) begin
			next_q.irq_enable = wdata_i[1:0];
		end
		// Register reads, answered next cycle
		if (rd_i) begin
			case (addr_i)
				selection_register_offset: next_q.rdata = q.selection_register;
				control_status_a_offset: next_q.rdata = {q.enable, q.start_busy, q.auto_trig,
					q.done_flag, q.done_ie, q.presc_sel};
				irq_status_offset: next_q.rdata = {6'h00, q.irq_status};
				irq_enable_offset: next_q.rdata = {6'h00, q.irq_enable};
				sleep_control_offset: next_q.rdata = {5'h00, q.sleep_armed, q.state};
				default: next_q.rdata = 8'h00;
			endcase
		end
		// Synchronous reset
		if (!rst_n_i) begin
			next_q = '0;
			next_q.state = st_idle_type;
			next_q.selection_register = selection_reset;
		end
	end

	// State register
	always_ff @(posedge clk_sys_i) begin
		q <= next_q;
	end

	// Analog switch decode from the effective selection
	assign ref_sel_o = q.eff.ref_sel;
	assign chan_sel_o = q.eff.chan_sel;
	assign ref_pin_o = q.enable && q.eff.ref_sel == ref_pin_code; // R15 R17
	assign ref_supply_o = q.enable && q.eff.ref_sel == ref_supply_code; // R15
	assign ref_internal_o = q.enable && q.eff.ref_sel == ref_internal_code; // R15
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_in
			assign input_onehot_o[gi] = q.enable && q.eff.chan_sel == 4'(gi); // R16
		end
	endgenerate
	assign temp_sel_o = q.enable && q.eff.chan_sel == chan_temp_code; // R16
	assign bandgap_sel_o = q.enable && q.eff.chan_sel == chan_bandgap_code; // R16
	assign ground_sel_o = q.enable && q.eff.chan_sel == chan_ground_code; // R16
	assign sample_o = q.state != st_idle_type;
	assign result_o = q.result;
	assign rdata_o = q.rdata;
	assign done_irq_o = q.done_flag && q.done_ie; // R11
	assign wake_o = q.irq_status[irq_wake_bit] && q.irq_enable[irq_wake_bit]; // R11
	assign irq_o = |(q.irq_status & q.irq_enable);

endmodule : adc_select_update_ctrl

// ==== adc_select_pkg.sv ====
// Package for the converter selection and update control block.
// Assumes one system clock; the converter clock is derived by a prescaler.
package adc_select_pkg;

	// Register offsets (byte addresses)
	localparam logic [7:0] selection_register_offset = 8'h7c;
	localparam logic [7:0] control_status_a_offset = 8'h7a;
	localparam logic [7:0] irq_status_offset = 8'h80;
	localparam logic [7:0] irq_enable_offset = 8'h81;
	localparam logic [7:0] irq_clear_offset = 8'h82;
	localparam logic [7:0] sleep_control_offset = 8'h83;

	// Selection register fields
	localparam int ref_msb = 7;
	localparam int ref_lsb = 6;
	localparam int left_adjust_bit = 5;
	localparam int chan_msb = 3;
	localparam int chan_lsb = 0;

	// Control and status A fields
	localparam int enable_bit = 7;
	localparam int start_bit = 6;
	localparam int auto_trig_bit = 5;
	localparam int done_flag_bit = 4;
	localparam int done_ie_bit = 3;
	localparam int presc_msb = 2;

	// Interrupt status bit positions
	localparam int irq_done_bit = 0;
	localparam int irq_wake_bit = 1;

	// Reset values
	localparam logic [7:0] selection_reset = 8'h00;
	localparam logic [7:0] control_reset = 8'h00;

	// Conversion lengths in converter clock cycles
	localparam logic [4:0] normal_conv_cycles = 5'h0d;
	localparam logic [4:0] first_conv_cycles = 5'h19;

	// Reference codes
	localparam logic [1:0] ref_pin_code = 2'h0;
	localparam logic [1:0] ref_supply_code = 2'h1;
	localparam logic [1:0] ref_reserved_code = 2'h2;
	localparam logic [1:0] ref_internal_code = 2'h3;

	// Channel codes
	localparam logic [3:0] chan_last_input = 4'h7;
	localparam logic [3:0] chan_temp_code = 4'h8;
	localparam logic [3:0] chan_bandgap_code = 4'he;
	localparam logic [3:0] chan_ground_code = 4'hf;

	// Full scale result
	localparam logic [9:0] full_scale_code = 10'h3ff;

	// Sleep mode codes from the CPU
	localparam logic [2:0] sleep_idle_code = 3'h0;
	localparam logic [2:0] sleep_noise_code = 3'h1;

	// Converter sequencer states
	typedef enum logic [1:0] {
		st_idle_type = 2'b00,
		st_convert_type = 2'b01,
		st_last_type = 2'b10
	} conv_state_type;

	// Effective selection driven to the analog side
	typedef struct packed {
		logic [1:0] ref_sel;
		logic [3:0] chan_sel;
	} eff_sel_type;

	// Complete block state
	typedef struct packed {
		conv_state_type state;
		logic [7:0] selection_register;
		logic enable;
		logic start_pending;
		logic start_busy;
		logic auto_trig;
		logic done_flag;
		logic done_ie;
		logic [2:0] presc_sel;
		logic [6:0] presc_cnt;
		logic first_conv;
		logic [4:0] cycle_cnt;
		eff_sel_type eff;
		logic trig_q;
		logic sleep_armed;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		logic [7:0] rdata;
		logic [9:0] result;
	} state_type;

endpackage : adc_select_pkg

// ==== adc_select_sva.sv ====
// Port checker for the converter selection and update control block.
// Bound from the testbench top; sees only the block's own ports.
`timescale 1ns/1ps
module adc_select_sva
	import adc_select_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic irq_ack_i,
	input wire logic over_ref_i,
	input wire logic [1:0] ref_sel_o,
	input wire logic [3:0] chan_sel_o,
	input wire logic ref_pin_o,
	input wire logic ref_supply_o,
	input wire logic ref_internal_o,
	input wire logic [7:0] input_onehot_o,
	input wire logic temp_sel_o,
	input wire logic bandgap_sel_o,
	input wire logic ground_sel_o,
	input wire logic sample_o,
	input wire logic [9:0] result_o,
	input wire logic done_irq_o,
	input wire logic wake_o,
	input wire logic irq_o
);
	// All checks on the system clock
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_sel_frozen: assert property (
		$rose(sample_o) |=> $stable({ref_sel_o, chan_sel_o})[*8]) else $error("selection moved");
	chk_conv_busy: assert property (
		$rose(sample_o) |=> sample_o[*8]) else $error("conversion too short");
	chk_start_tick: assert property (
		wr_i && addr_i == control_status_a_offset && wdata_i[enable_bit] && wdata_i[start_bit]
		&& !sample_o |-> ##[1:300] sample_o) else $error("start not taken");
	chk_ref_decode: assert property (
		{ref_pin_o, ref_supply_o, ref_internal_o} == 3'h0 || {ref_pin_o, ref_supply_o,
		ref_internal_o} == {ref_sel_o == ref_pin_code, ref_sel_o == ref_supply_code,
		ref_sel_o == ref_internal_code}) else $error("reference decode wrong");
	chk_chan_decode: assert property (
		input_onehot_o == 8'h00 || (chan_sel_o <= chan_last_input
		&& input_onehot_o == 8'h01 << chan_sel_o[2:0])) else $error("input decode wrong");
	chk_aux_decode: assert property (
		{temp_sel_o, bandgap_sel_o, ground_sel_o} == 3'h0 || {temp_sel_o, bandgap_sel_o,
		ground_sel_o} == {chan_sel_o == chan_temp_code, chan_sel_o == chan_bandgap_code,
		chan_sel_o == chan_ground_code}) else $error("special channel decode wrong");
	chk_ack_clears: assert property (
		irq_ack_i && !sample_o |=> !done_irq_o) else $error("vector did not clear request");
	chk_full_scale: assert property (
		$fell(sample_o) && $past(over_ref_i) |-> result_o == full_scale_code)
		else $error("over-reference result not full scale");
	chk_wake_line: assert property (
		$rose(wake_o) |-> $fell(sample_o) || $past(wr_i))
		else $error("wake request without completion");
endmodule : adc_select_sva

// ==== cpu_core_model.sv ====
// CPU core model: master of the register port of the converter block.
// Drives just after rising edges; read data taken the cycle after a read.
`timescale 1ns/1ps
module cpu_core_model (
	input wire logic clk_sys_i,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [7:0] rdata_i
);
	// Idle bus at time zero
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// One-cycle write; released lines show inverted values
	task automatic write(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		addr_o <= a;
		wdata_o <= v;
		wr_o <= 1'b1;
		@(posedge clk_sys_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~v;
	endtask : write
	// One-cycle read; data sampled in the following cycle
	task automatic read(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_sys_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_sys_i);
		v = rdata_i;
	endtask : read
endmodule : cpu_core_model

// ==== tb_adc_select_update_ctrl.sv ====
// Self-checking testbench for the converter selection and update control.
// Assumes one 25 MHz clock; the CPU core model owns the register port.
`timescale 1ns/1ps
module tb_adc_select_update_ctrl;
	import adc_select_pkg::*;
	logic clk_sys_i = 1'b0, rst_n_i = 1'b0, trigger_i = 1'b0, free_run_i = 1'b0;
	logic cpu_halted_i = 1'b0, over_ref_i = 1'b0, irq_ack_i = 1'b0, wr_i, rd_i;
	logic ref_pin_o, ref_supply_o, ref_internal_o, temp_sel_o, bandgap_sel_o, ground_sel_o;
	logic sample_o, done_irq_o, wake_o, irq_o;
	logic [7:0] addr_i, wdata_i, rdata_o, input_onehot_o, d;
	logic [2:0] sleep_mode_i = 3'h2;
	logic [9:0] sar_code_i = 10'h000, result_o;
	logic [1:0] ref_sel_o;
	logic [3:0] chan_sel_o, ca, cb;
	logic [13:0] dec;
	int fails = 0, check_count = 0, cycles = 0;
	assign dec = {ref_pin_o, ref_supply_o, ref_internal_o, input_onehot_o, temp_sel_o,
		bandgap_sel_o, ground_sel_o};
	adc_select_update_ctrl u_dut (.*);
	cpu_core_model u_cpu (.clk_sys_i(clk_sys_i), .addr_o(addr_i), .wdata_o(wdata_i),
		.wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));
	always #20 clk_sys_i = ~clk_sys_i;
	// Hang guard
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			final_report();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Expected decode of a {reference, channel} pair with the converter on
	function automatic logic [13:0] exp_dec(input logic [5:0] s);
		return {s[5:4] == ref_pin_code, s[5:4] == ref_supply_code, s[5:4] == ref_internal_code,
			(s[3:0] <= chan_last_input) ? 8'h01 << s[2:0] : 8'h00, s[3:0] == chan_temp_code,
			s[3:0] == chan_bandgap_code, s[3:0] == chan_ground_code};
	endfunction : exp_dec
	task automatic ack();
		irq_ack_i <= 1'b1;
		@(posedge clk_sys_i);
		irq_ack_i <= 1'b0;
	endtask : ack
	// Conversion with a selection change inside the safe window
	task automatic conv_case(input logic [7:0] ctrl, input logic trig);
		ca = 4'($urandom % 8);
		cb = ca ^ 4'h5;
		sar_code_i <= 10'($urandom);
		ack();
		u_cpu.write(selection_register_offset, {ref_supply_code, 2'h0, ca});
		u_cpu.write(control_status_a_offset, ctrl);
		trigger_i <= trig;
		wait (sample_o === 1'b1);
		repeat (4) @(posedge clk_sys_i);
		chk(done_irq_o, 1'b0);
		u_cpu.write(selection_register_offset, {ref_supply_code, 2'h0, cb});
		@(posedge clk_sys_i);
		chk(chan_sel_o, ca);
		u_cpu.read(control_status_a_offset, d);
		chk(d[start_bit], 1'b1);
		wait (sample_o === 1'b0);
		@(posedge clk_sys_i);
		trigger_i <= 1'b0;
		chk(chan_sel_o, cb);
		chk(result_o, over_ref_i ? full_scale_code : sar_code_i);
		chk(done_irq_o, 1'b1);
	endtask : conv_case
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report
	initial begin
		void'($urandom(32'ha73d59b5));
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		u_cpu.read(control_status_a_offset, d);
		chk(d, control_reset);
		u_cpu.read(8'h90, d);
		chk(d, 8'h00);
		// Converter off: effective selection held, decode stays dark
		u_cpu.write(selection_register_offset, 8'hc8);
		repeat (2) @(posedge clk_sys_i);
		chk(dec, 14'h0000);
		chk(chan_sel_o, selection_reset[chan_msb:chan_lsb]);
		u_cpu.write(control_status_a_offset, 8'h80);
		for (int i = 0; i < 16; i++) begin
			u_cpu.write(selection_register_offset, {i[1:0], 2'h0, i[3:0]});
			repeat (2) @(posedge clk_sys_i);
			chk(dec, exp_dec({i[1:0], i[3:0]}));
			u_cpu.read(selection_register_offset, d);
			chk(d, {i[1:0], 2'h0, i[3:0]});
			chk({ref_sel_o, chan_sel_o}, {i[1:0], i[3:0]});
		end
		conv_case(8'hc8, 1'b0);
		over_ref_i <= 1'b1;
		conv_case(8'hc8, 1'b0);
		over_ref_i <= 1'b0;
		conv_case(8'ha8, 1'b1);
		// Zero start bit, then sleep entry with an early wake
		u_cpu.write(control_status_a_offset, 8'h88);
		ack();
		repeat (4) @(posedge clk_sys_i);
		chk(sample_o, 1'b0);
		sleep_mode_i <= 3'($urandom % 2);
		cpu_halted_i <= 1'b1;
		wait (sample_o === 1'b1);
		@(posedge clk_sys_i);
		cpu_halted_i <= 1'b0;
		chk(sample_o, 1'b1);
		wait (sample_o === 1'b0);
		@(posedge clk_sys_i);
		chk(done_irq_o, 1'b1);
		// Interrupt status masked, unmasked and cleared
		u_cpu.write(irq_enable_offset, 8'h00);
		@(posedge clk_sys_i);
		chk(irq_o, 1'b0);
		u_cpu.write(irq_enable_offset, 8'h03);
		@(posedge clk_sys_i);
		chk(irq_o, 1'b1);
		u_cpu.read(irq_status_offset, d);
		chk(d[irq_done_bit], 1'b1);
		chk(d[irq_wake_bit], 1'b0);
		u_cpu.write(irq_clear_offset, 8'h03);
		@(posedge clk_sys_i);
		chk(irq_o, 1'b0);
		// Other sleep modes neither start nor disable
		sleep_mode_i <= 3'h2 + 3'($urandom % 6);
		cpu_halted_i <= 1'b1;
		repeat (20) @(posedge clk_sys_i);
		chk(sample_o, 1'b0);
		u_cpu.read(control_status_a_offset, d);
		chk(d[enable_bit], 1'b1);
		cpu_halted_i <= 1'b0;
		// Noise canceler left to finish: completion raises the wake request
		@(posedge clk_sys_i);
		sleep_mode_i <= sleep_noise_code;
		cpu_halted_i <= 1'b1;
		wait (sample_o === 1'b1);
		wait (sample_o === 1'b0);
		@(posedge clk_sys_i);
		chk(wake_o, 1'b1);
		chk(irq_o, 1'b1);
		cpu_halted_i <= 1'b0;
		u_cpu.write(irq_clear_offset, 8'h03);
		@(posedge clk_sys_i);
		chk(wake_o, 1'b0);
		// Free running: change after first result
		ack();
		free_run_i <= 1'b1;
		u_cpu.write(selection_register_offset, {ref_supply_code, 2'h0, ca});
		u_cpu.write(control_status_a_offset, 8'he8);
		wait (done_irq_o === 1'b1);
		@(posedge clk_sys_i);
		u_cpu.write(selection_register_offset, {ref_supply_code, 2'h0, cb});
		@(posedge clk_sys_i);
		chk(chan_sel_o, ca);
		repeat (60) @(posedge clk_sys_i);
		chk(chan_sel_o, cb);
		chk(sample_o, 1'b1);
		u_cpu.write(control_status_a_offset, 8'h00);
		free_run_i <= 1'b0;
		final_report();
	end
endmodule : tb_adc_select_update_ctrl
bind adc_select_update_ctrl adc_select_sva u_sva (.*);
